//--- bench/srp_asserts.sv
// Link checker for the serial register port, both ends
`timescale 1ns/10ps
module srp_asserts (
	input wire logic clk_i,	// Host clock
	input wire logic rst_b_i,	// Reset, active low
	input wire logic serial_clk,	// Link clock
	input wire logic frame_enable_n,	// Frame enable, active low
	input wire logic host_data,	// Host data toward shared pin
	input wire logic host_data_oe,	// Host drives shared pin
	input wire logic dev_data,	// Device data toward shared pin
	input wire logic dev_data_oe,	// Device drives shared pin
	input wire logic dev_rdo_oe	// Device drives read pin
);
	logic sclk_q;
	logic fe_q;
	logic [5:0] cnt_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Counts link clock rises in the current frame
	always_ff @(posedge clk_i) begin
		sclk_q <= serial_clk;
		fe_q <= frame_enable_n;
		if (!rst_b_i || (fe_q && !frame_enable_n)) cnt_q <= 6'h00;
		else if (serial_clk && !sclk_q) cnt_q <= cnt_q + 6'h01;
	end
	property p_idle_clk; frame_enable_n |-> !serial_clk; endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("link clock runs outside frame");
	property p_no_clash; !(host_data_oe && dev_data_oe); endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive shared pin");
	property p_rdo_excl; dev_rdo_oe |-> !dev_data_oe; endproperty
	a_rdo_excl: assert property (p_rdo_excl) else $error("shared pin driven in four wire mode");
	property p_dev_in_frame; dev_data_oe |-> !frame_enable_n; endproperty
	a_dev_in_frame: assert property (p_dev_in_frame) else $error("shared pin held after frame");
	property p_dev_launch; $rose(dev_data_oe) |-> !host_data_oe && !serial_clk; endproperty
	a_dev_launch: assert property (p_dev_launch) else $error("device drive starts badly");
	property p_dev_change; dev_data_oe && $changed(dev_data) |-> !serial_clk; endproperty
	a_dev_change: assert property (p_dev_change) else $error("read bit not launched on fall");
	property p_host_change; !frame_enable_n && $changed(host_data) |-> !serial_clk; endproperty
	a_host_change: assert property (p_host_change) else $error("host bit changes while clock high");
	property p_start_drive; $fell(frame_enable_n) |-> host_data_oe; endproperty
	a_start_drive: assert property (p_start_drive) else $error("instruction not driven at start");
	property p_frame_len; $rose(frame_enable_n) |-> cnt_q[2:0] == 3'h0 && cnt_q >= 6'h10 && cnt_q <= 6'h28;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length not two to five bytes");
	c_read3: cover property ($rose(dev_data_oe));
	c_long: cover property ($rose(frame_enable_n) && cnt_q == 6'h28);
	c_read4: cover property (dev_rdo_oe && !frame_enable_n);
endmodule

//--- bench/tb.sv
// Testbench for the serial register port, host and device joined
`timescale 1ns/10ps
module tb;
	import srp_pkg::*;
	logic clk;
	logic rst_b;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	logic upd;
	logic four_wire;
	logic [3:0] sel;
	logic [3:0] a;
	logic [7:0] val;
	int n_mismatch = 0;
	int checked = 0;
	int n_upd = 0;
	srp_if link();
	srp_host #(.SCLK_HALF(2)) i_srp_host (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .link(link));
	srp_device i_srp_device (.clk_i(clk), .rst_b_i(rst_b), .link(link), .cfg_sel_i(sel), .cfg_val_o(val),
		.cfg_upd_o(upd), .four_wire_o(four_wire));
	srp_asserts u_asserts (.clk_i(clk), .rst_b_i(rst_b), .serial_clk(link.serial_clk),
		.frame_enable_n(link.frame_enable_n), .host_data(link.host_data), .host_data_oe(link.host_data_oe),
		.dev_data(link.dev_data), .dev_data_oe(link.dev_data_oe), .dev_rdo_oe(link.dev_rdo_oe));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Counts bank update pulses seen on the user side
	always @(posedge clk) begin
		if (upd === 1'b1) begin
			n_upd <= n_upd + 1;
		end
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; read data and error land in rd and err
	task automatic apb(input logic w, input logic [7:0] adr, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= adr;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_mismatch++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Starts a frame and polls busy until the link is idle again
	task automatic frame(input logic [7:0] cmd, input logic [31:0] wd);
		int k;
		apb(1'b1, WDATA_OFS, wd);
		apb(1'b1, CMD_OFS, {24'h000000, cmd});
		k = 0;
		do begin
			apb(1'b0, STATUS_OFS, 32'h00000000);
			k++;
		end while (rd[0] !== 1'b0 && k < 100);
		if (k >= 100) begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	task automatic chk_reg(input logic [3:0] ra, input logic [7:0] exp);
		sel <= ra;
		repeat (3) @(posedge clk);
		chk("mode register", {24'h000000, exp}, {24'h000000, val});
	endtask
	initial begin
		rst_b <= 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		sel = 4'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, STATUS_OFS, 32'h00000000);
		chk("status", APB_RESET, rd);
		apb(1'b0, 8'h14, 32'h00000000);
		chk("unmapped error", 32'h00000001, {31'h0, err});
		chk("unmapped data", 32'h00000000, rd);
		chk("four wire flag", 32'h00000000, {31'h0, four_wire});
		$display("test reset done");
		// One to four byte writes, start address counting down
		for (int n = 0; n < 4; n++) begin
			a = (n == 3) ? 4'h3 : 4'(4 * n + 4);
			frame({1'b0, 2'(n), 1'b0, a}, 32'hA53C8196);
			for (int b = 0; b <= n; b++) chk_reg(a - 4'(b), 8'(32'hA53C8196 >> (24 - 8 * b)));
			if (n < 3) chk_reg(a - 4'(n + 1), 8'h00);
		end
		chk("update pulses", 32'h0000000A, 32'(n_upd));
		$display("test write done");
		frame(8'hE3, 32'h00000000);
		apb(1'b0, RDATA_OFS, 32'h00000000);
		chk("three wire read", 32'hA53C8196, rd);
		frame(8'hA8, 32'h00000000);
		apb(1'b0, RDATA_OFS, 32'h00000000);
		chk("two byte read", 32'hA53C0000, rd);
		$display("test three wire read done");
		frame({4'h0, MODE_HIGH_CONFIG_ADDR}, 32'h40000000);
		apb(1'b1, CTRL_OFS, 32'h00000001);
		repeat (4) @(posedge clk);
		chk("four wire flag", 32'h00000001, {31'h0, four_wire});
		chk("read pin drive", 32'h00000001, {31'h0, link.dev_rdo_oe});
		frame(8'hE3, 32'h00000000);
		apb(1'b0, RDATA_OFS, 32'h00000000);
		chk("four wire read", 32'hA53C4096, rd);
		frame(8'h01, 32'h00000000);
		apb(1'b1, CTRL_OFS, 32'h00000000);
		frame(8'h81, 32'h00000000);
		apb(1'b0, RDATA_OFS, 32'h00000000);
		chk("mode readback", 32'h00000000, rd);
		chk("update pulses", 32'h0000000C, 32'(n_upd));
		$display("test four wire done");
		print_verdict();
	end
endmodule

//--- pkg/srp_if.sv
// Serial link between host and device, with pin resolution
`timescale 1ns/10ps
interface srp_if;
	logic serial_clk;
	logic frame_enable_n;
	logic host_data;
	logic host_data_oe;
	logic dev_data;
	logic dev_data_oe;
	logic dev_rdo;
	logic dev_rdo_oe;
	logic bidir_data_pin;
	logic read_data_out_pin;

	// Undriven lines float high as if pulled up
	assign bidir_data_pin = host_data_oe ? host_data : (dev_data_oe ? dev_data : 1'b1);
	assign read_data_out_pin = dev_rdo_oe ? dev_rdo : 1'b1;

	modport dev (
		input serial_clk,
		input frame_enable_n,
		input bidir_data_pin,
		output dev_data,
		output dev_data_oe,
		output dev_rdo,
		output dev_rdo_oe
	);
	modport host (
		output serial_clk,
		output frame_enable_n,
		output host_data,
		output host_data_oe,
		input bidir_data_pin,
		input read_data_out_pin
	);
endinterface

//--- pkg/srp_pkg.sv
// Shared constants of the serial register port, both ends
package srp_pkg;
	// Instruction byte layout
	localparam int RW_BIT = 7;
	localparam int CNT_HI = 6;
	localparam int CNT_LO = 5;
	localparam int ADDR_HI = 3;
	localparam int ADDR_W = 4;
	localparam int NUM_REGS = 16;
	localparam int BYTE_W = 8;
	// Mode register holding the wire-count select
	localparam logic [3:0] MODE_HIGH_CONFIG_ADDR = 4'h1;
	localparam int FOUR_WIRE_BIT = 6;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Byte slots in a frame
	localparam logic [2:0] INSTR_SLOT = 3'h0;
	localparam logic [2:0] PAST_SLOT = 3'h6;
	// Host timing, link clock made from clk_i
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCLK_LOW_NS = 40;
	localparam int SCLK_HALF_CYC = (SCLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host APB register offsets
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] WDATA_OFS = 8'h04;
	localparam logic [7:0] RDATA_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] CTRL_OFS = 8'h10;
	localparam logic [31:0] APB_RESET = 32'h0000_0000;
endpackage

//--- rtl/srp_device.sv
// Serial register port, device end: link shift logic and mode register bank
`timescale 1ns/10ps
module srp_device (
	input wire logic clk_i,	// User-side clock
	input wire logic rst_b_i,	// Reset, active low
	srp_if.dev link,	// Serial link
	input wire logic [srp_pkg::ADDR_W-1:0] cfg_sel_i,	// Register shown on cfg_val_o
	output logic [7:0] cfg_val_o,	// Selected mode register
	output logic cfg_upd_o,	// Pulse: bank copy refreshed
	output logic four_wire_o	// Four-wire mode in force
);
	import srp_pkg::*;

	// Link domain, clocked by the host's serial clock
	logic [2:0] bit_q;
	logic [2:0] byte_q;
	logic [7:0] shift_q;
	logic rd_q;
	logic [1:0] cnt_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0] bank_q [NUM_REGS];
	logic wr_tog_q;
	logic out_bit_q;
	logic dev_oe_q;

	// User domain
	logic [2:0] tog_sync_q;
	logic [1:0] fw_sync_q;
	logic [7:0] mirror_q [NUM_REGS];
	logic [7:0] cfg_val_q;
	logic cfg_upd_q;
	logic four_wire_q;

	// A raised enable aborts whatever byte is in flight
	wire logic link_clr = link.frame_enable_n || !rst_b_i;
	wire logic byte_done = (bit_q == 3'h7);
	wire logic [7:0] rx_byte = {shift_q[6:0], link.bidir_data_pin};
	wire logic [2:0] last_slot = {1'b0, cnt_q} + 3'h1;
	wire logic in_data = (byte_q != INSTR_SLOT) && (byte_q <= last_slot);
	wire logic wr_en = byte_done && in_data && !rd_q;
	wire logic four_wire = bank_q[MODE_HIGH_CONFIG_ADDR][FOUR_WIRE_BIT];
	wire logic [2:0] out_idx = 3'h7 - bit_q;
	wire logic bank_changed = tog_sync_q[2] ^ tog_sync_q[1];

	// Bit and byte tracking within one frame
	always_ff @(posedge link.serial_clk or posedge link_clr) begin
		if (link_clr) begin
			bit_q <= 3'h0;
			byte_q <= INSTR_SLOT;
			shift_q <= 8'h00;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
			addr_q <= '0;
		end else begin
			bit_q <= bit_q + 3'h1;
			shift_q <= rx_byte;
			if (byte_done) begin
				if (byte_q != PAST_SLOT) begin
					byte_q <= byte_q + 3'h1;
				end
				if (byte_q == INSTR_SLOT) begin
					rd_q <= rx_byte[RW_BIT];
					cnt_q <= rx_byte[CNT_HI:CNT_LO];
					addr_q <= rx_byte[ADDR_HI:0];
				end else begin
					addr_q <= addr_q - 4'h1;
				end
			end
		end
	end

	// Register bank keeps its contents across frames
	always_ff @(posedge link.serial_clk or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				bank_q[i] <= REG_RESET;
			end
			wr_tog_q <= 1'b0;
		end else if (wr_en) begin
			bank_q[addr_q] <= rx_byte;
			wr_tog_q <= ~wr_tog_q;
		end
	end

	// Read data launched a full period ahead of the host's sampling edge
	always_ff @(negedge link.serial_clk or posedge link_clr) begin
		if (link_clr) begin
			out_bit_q <= 1'b0;
			dev_oe_q <= 1'b0;
		end else begin
			out_bit_q <= (rd_q && in_data) ? bank_q[addr_q][out_idx] : 1'b0;
			dev_oe_q <= rd_q && in_data && !four_wire;
		end
	end

	assign link.dev_data = out_bit_q;
	assign link.dev_data_oe = dev_oe_q;
	assign link.dev_rdo = out_bit_q;
	assign link.dev_rdo_oe = four_wire;

	// Bank copy into the user domain: a toggle per write crosses, then the
	// whole bank is sampled. The next write is a full byte of link clock away,
	// so the bank is stable while it is copied.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			tog_sync_q <= 3'h0;
			fw_sync_q <= 2'h0;
			cfg_upd_q <= 1'b0;
			cfg_val_q <= REG_RESET;
			four_wire_q <= 1'b0;
			for (int i = 0; i < NUM_REGS; i++) begin
				mirror_q[i] <= REG_RESET;
			end
		end else begin
			tog_sync_q <= {tog_sync_q[1:0], wr_tog_q};
			fw_sync_q <= {fw_sync_q[0], four_wire};
			cfg_upd_q <= bank_changed;
			cfg_val_q <= mirror_q[cfg_sel_i];
			four_wire_q <= fw_sync_q[1];
			if (bank_changed) begin
				for (int i = 0; i < NUM_REGS; i++) begin
					mirror_q[i] <= bank_q[i];
				end
			end
		end
	end

	assign cfg_val_o = cfg_val_q;
	assign cfg_upd_o = cfg_upd_q;
	assign four_wire_o = four_wire_q;
endmodule

//--- rtl/srp_host.sv
// Serial register port, host end: APB command registers and frame generator
`timescale 1ns/10ps
module srp_host #(
	parameter int SCLK_HALF = srp_pkg::SCLK_HALF_CYC	// clk_i cycles per link clock half period
) (
	input wire logic clk_i,	// System clock
	input wire logic rst_b_i,	// Synchronous reset, active low
	input wire logic psel_i,	// APB select
	input wire logic penable_i,	// APB enable
	input wire logic pwrite_i,	// APB direction
	input wire logic [7:0] paddr_i,	// APB byte address
	input wire logic [31:0] pwdata_i,	// APB write data
	output logic [31:0] prdata_o,	// APB read data
	output logic pready_o,	// APB ready
	output logic pslverr_o,	// APB error on unmapped address
	srp_if.host link	// Serial link
);
	import srp_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_END} srp_state_t;

	srp_state_t state_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic four_wire_q;
	logic [3:0] half_q;
	logic sclk_q;
	logic fen_q;
	logic oe_q;
	logic rd_q;
	logic [1:0] cnt_q;
	logic [39:0] tx_q;
	logic [31:0] rx_q;
	logic [5:0] bit_q;
	logic [5:0] last_q;
	logic [1:0] bidir_sync_q;
	logic [1:0] rdo_sync_q;

	wire logic setup = psel_i && !penable_i;
	wire logic access = psel_i && penable_i && pready_q;
	wire logic mapped = (paddr_i == CMD_OFS) || (paddr_i == WDATA_OFS) || (paddr_i == RDATA_OFS)
		|| (paddr_i == STATUS_OFS) || (paddr_i == CTRL_OFS);
	wire logic wr_cmd = access && pwrite_i && (paddr_i == CMD_OFS);
	wire logic start = wr_cmd && (state_q == ST_IDLE);
	wire logic half_end = (half_q == 4'(SCLK_HALF - 1));
	wire logic fall = half_end && sclk_q;
	wire logic din = four_wire_q ? rdo_sync_q[1] : bidir_sync_q[1];
	wire logic [31:0] rd_mux = (paddr_i == WDATA_OFS) ? wdata_q :
		(paddr_i == RDATA_OFS) ? rdata_q :
		(paddr_i == STATUS_OFS) ? {31'h0000_0000, state_q != ST_IDLE} :
		(paddr_i == CTRL_OFS) ? {31'h0000_0000, four_wire_q} : 32'h0000_0000;

	// Zero-wait APB slave: answer in the cycle after setup
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			prdata_q <= APB_RESET;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			wdata_q <= APB_RESET;
			four_wire_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			if (setup) begin
				prdata_q <= rd_mux;
			end
			if (access && pwrite_i && (paddr_i == WDATA_OFS)) begin
				wdata_q <= pwdata_i;
			end
			if (access && pwrite_i && (paddr_i == CTRL_OFS)) begin
				four_wire_q <= pwdata_i[0];
			end
		end
	end

	// Read data arrives on a foreign clock edge, so it is synchronised first
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			bidir_sync_q <= 2'h3;
			rdo_sync_q <= 2'h3;
		end else begin
			bidir_sync_q <= {bidir_sync_q[0], link.bidir_data_pin};
			rdo_sync_q <= {rdo_sync_q[0], link.read_data_out_pin};
		end
	end

	// Frame generator: clock low HALF cycles, high HALF cycles, data moved at falls
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q <= ST_IDLE;
			half_q <= 4'h0;
			sclk_q <= 1'b0;
			fen_q <= 1'b1;
			oe_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
			tx_q <= 40'h00_0000_0000;
			rx_q <= 32'h0000_0000;
			bit_q <= 6'h00;
			last_q <= 6'h00;
			rdata_q <= APB_RESET;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_SHIFT;
						fen_q <= 1'b0;
						oe_q <= 1'b1;
						tx_q <= {pwdata_i[7:0], wdata_q};
						rd_q <= pwdata_i[RW_BIT];
						cnt_q <= pwdata_i[CNT_HI:CNT_LO];
						last_q <= {3'(pwdata_i[CNT_HI:CNT_LO]) + 3'h2, 3'h0} - 6'h01;
						bit_q <= 6'h00;
						half_q <= 4'h0;
						rx_q <= 32'h0000_0000;
					end
				end
				ST_SHIFT: begin
					half_q <= half_end ? 4'h0 : half_q + 4'h1;
					if (half_end && !sclk_q) begin
						sclk_q <= 1'b1;
					end
					if (fall) begin
						sclk_q <= 1'b0;
						if (rd_q && bit_q >= 6'h08) begin
							rx_q <= {rx_q[30:0], din};
						end
						if (rd_q && bit_q == 6'h07) begin
							oe_q <= 1'b0;
						end
						if (bit_q == last_q) begin
							state_q <= ST_END;
						end else begin
							bit_q <= bit_q + 6'h01;
							tx_q <= {tx_q[38:0], 1'b0};
						end
					end
				end
				ST_END: begin
					half_q <= half_end ? 4'h0 : half_q + 4'h1;
					if (half_end) begin
						state_q <= ST_IDLE;
						fen_q <= 1'b1;
						oe_q <= 1'b0;
						if (rd_q) begin
							rdata_q <= rx_q << {~cnt_q, 3'h0};
						end
					end
				end
			endcase
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign link.serial_clk = sclk_q;
	assign link.frame_enable_n = fen_q;
	assign link.host_data = tx_q[39];
	assign link.host_data_oe = oe_q;
endmodule
